// File: src/tcou_consts.vh
`ifndef TCOU_CONSTS_VH
`define TCOU_CONSTS_VH
// Register byte addresses.
`define TCOU_OFF_CTRL 8'h00
`define TCOU_OFF_FLAGS 8'h04
`define TCOU_OFF_FORCE 8'h08
`define TCOU_OFF_STATUS 8'h0C
`define TCOU_OFF_CMPA_LO 8'h10
`define TCOU_OFF_CMPA_HI 8'h14
`define TCOU_OFF_CMPB_LO 8'h18
`define TCOU_OFF_CMPB_HI 8'h1C
`define TCOU_OFF_CAP_LO 8'h20
`define TCOU_OFF_CAP_HI 8'h24
// Register select codes.
`define TCOU_SEL_CTRL 4'h0
`define TCOU_SEL_FLAGS 4'h1
`define TCOU_SEL_FORCE 4'h2
`define TCOU_SEL_STATUS 4'h3
`define TCOU_SEL_CMP_LO 4'h4
`define TCOU_SEL_CAP_LO 4'h8
`define TCOU_SEL_CAP_HI 4'h9
`define TCOU_SEL_NONE 4'hF
// Control register fields.
`define TCOU_CTRL_ACT_LSB 0
`define TCOU_CTRL_IE_LSB 4
`define TCOU_CTRL_CAP_IE 6
`define TCOU_CTRL_RESET 8'h00
// Flag bit of the capture unit, after the compare flags.
`define TCOU_FLAG_CAP 2
// Compare output actions.
`define TCOU_ACT_NONE 2'h0
`define TCOU_ACT_TOGGLE 2'h1
`define TCOU_ACT_CLEAR 2'h2
`define TCOU_ACT_SET 2'h3
// Waveform modes that are not PWM.
`define TCOU_WGM_NORMAL 4'h0
`define TCOU_WGM_CTC_A 4'h4
`define TCOU_WGM_CTC_CAP 4'hC
`define TCOU_WGM_RESERVED 4'hD
// Bus answers.
`define TCOU_RESP_OKAY 2'h0
`define TCOU_RESP_DECERR 2'h3
`endif

// File: src/tcou_top.v
`timescale 1ns/1ps
// Function
// - A capture event copies the counter and sets the capture flag in one cycle.
// - A new capture overwrites the capture register whether read or not.
// - Each channel compares the full 16-bit counter with its compare value.
// - Enabled flag requests interrupt; service or writing one clears it.
// - Channel A compare value can serve as the counter top.
// - Compare value is double-buffered in PWM modes, not in normal or clear-on-match.
// - Buffered value moves to active register only at counter top or floor.
// - Processor reaches the buffer when buffered, else the active register.
// - Compare value changes only by writes; high byte reads return it directly.
// - High byte goes to holding register; low write loads all 16 bits at once.
// - In non-PWM modes the force strobe acts like a match without flag.
// - A counter write blocks the compare equality seen at the next timer tick, even stopped.
// - Output state survives mode changes and resets to zero.
// - Output action is not buffered; it governs the next match after writing.
// - A nonzero action makes output state replace the port value on the pin.
// - Action zero leaves the output state unchanged at a match.
// - The output action has no influence on the capture unit.
`include "tcou_consts.vh"

module tcou_top (
	// Clock and reset.
	input wire SYS_CLK_IN,
	input wire RESET_IN,
	// AXI4-Lite write address, data and response.
	input wire [7:0] S_AXI_AWADDR_IN,
	input wire S_AXI_AWVALID_IN,
	output wire S_AXI_AWREADY_OUT,
	input wire [31:0] S_AXI_WDATA_IN,
	input wire [3:0] S_AXI_WSTRB_IN,
	input wire S_AXI_WVALID_IN,
	output wire S_AXI_WREADY_OUT,
	output wire [1:0] S_AXI_BRESP_OUT,
	output wire S_AXI_BVALID_OUT,
	input wire S_AXI_BREADY_IN,
	// AXI4-Lite read address and data.
	input wire [7:0] S_AXI_ARADDR_IN,
	input wire S_AXI_ARVALID_IN,
	output wire S_AXI_ARREADY_OUT,
	output wire [31:0] S_AXI_RDATA_OUT,
	output wire [1:0] S_AXI_RRESP_OUT,
	output wire S_AXI_RVALID_OUT,
	input wire S_AXI_RREADY_IN,
	// Counter unit, same clock domain.
	input wire TIMER_TICK_IN,
	input wire [15:0] COUNTER_VALUE_IN,
	input wire COUNTER_TOP_IN,
	input wire COUNTER_FLOOR_IN,
	input wire COUNTER_WRITE_IN,
	input wire [3:0] WAVEFORM_MODE_SELECT_IN,
	input wire CAPTURE_EVENT_IN,
	// Interrupt service acknowledges: capture, B, A.
	input wire [2:0] IRQ_ACK_IN,
	// Port logic per channel.
	input wire [1:0] PORT_VALUE_IN,
	input wire [1:0] PIN_DIRECTION_BIT_IN,
	// Outputs.
	output wire [15:0] COMPARE_A_TOP_OUT,
	output wire [2:0] IRQ_OUT,
	output wire [1:0] COMPARE_OUTPUT_STATE_OUT,
	output wire [1:0] PIN_OUT,
	output wire [1:0] PIN_OE_OUT
);

	localparam NCH = 2;

	// Decodes a byte address into a register select code.
	function [3:0] reg_sel;
		input [7:0] a;
		begin
			case (a)
				`TCOU_OFF_CTRL: reg_sel = `TCOU_SEL_CTRL;
				`TCOU_OFF_FLAGS: reg_sel = `TCOU_SEL_FLAGS;
				`TCOU_OFF_FORCE: reg_sel = `TCOU_SEL_FORCE;
				`TCOU_OFF_STATUS: reg_sel = `TCOU_SEL_STATUS;
				`TCOU_OFF_CMPA_LO: reg_sel = 4'h4;
				`TCOU_OFF_CMPA_HI: reg_sel = 4'h5;
				`TCOU_OFF_CMPB_LO: reg_sel = 4'h6;
				`TCOU_OFF_CMPB_HI: reg_sel = 4'h7;
				`TCOU_OFF_CAP_LO: reg_sel = `TCOU_SEL_CAP_LO;
				`TCOU_OFF_CAP_HI: reg_sel = `TCOU_SEL_CAP_HI;
				default: reg_sel = `TCOU_SEL_NONE;
			endcase
		end
	endfunction

	// The twelve PWM modes are all codes except normal, both clear-on-match and the reserved one.
	function is_pwm;
		input [3:0] m;
		begin
			is_pwm = !(m == `TCOU_WGM_NORMAL || m == `TCOU_WGM_CTC_A || m == `TCOU_WGM_CTC_CAP ||
				m == `TCOU_WGM_RESERVED);
		end
	endfunction

	reg aw_ready_reg;
	reg w_ready_reg;
	reg b_valid_reg;
	reg [1:0] b_resp_reg;
	reg [7:0] aw_addr_reg;
	reg [7:0] w_data_reg;
	reg w_lo_en_reg;
	reg ar_ready_reg;
	reg r_valid_reg;
	reg [1:0] r_resp_reg;
	reg [7:0] r_data_reg;
	reg [7:0] ctrl_reg;
	reg [2:0] flags_reg;
	reg [2:0] irq_reg;
	reg [7:0] temp_reg;
	reg [16*NCH-1:0] active_reg;
	reg [16*NCH-1:0] buffer_reg;
	reg [15:0] capture_reg;
	reg [NCH-1:0] seen_reg;
	reg block_reg;
	reg [NCH-1:0] state_reg;
	reg [NCH-1:0] pin_reg;
	reg [NCH-1:0] oe_reg;

	wire pwm = is_pwm(WAVEFORM_MODE_SELECT_IN);
	wire wr_go = !aw_ready_reg && !w_ready_reg && !b_valid_reg;
	wire [3:0] wr_sel = reg_sel(aw_addr_reg);
	wire [3:0] rd_sel = reg_sel(S_AXI_ARADDR_IN);
	wire rd_take = ar_ready_reg && S_AXI_ARVALID_IN;

	reg [2:0] flag_set;
	reg [2:0] flag_clr;
	reg [2:0] flags_next;
	reg [NCH-1:0] state_next;
	reg [NCH-1:0] match_fire;
	reg [NCH-1:0] act_fire;
	reg [1:0] act;
	reg [7:0] rd_data;
	reg rd_err;
	reg [15:0] view;
	integer i;

	// Flag, output state and read-mux decisions.
	always @* begin
		flag_set = 3'h0;
		flag_clr = IRQ_ACK_IN;
		state_next = state_reg;
		match_fire = {NCH{1'b0}};
		act_fire = {NCH{1'b0}};
		act = `TCOU_ACT_NONE;
		if (wr_go && w_lo_en_reg && wr_sel == `TCOU_SEL_FLAGS) begin
			flag_clr = flag_clr | w_data_reg[2:0];
		end
		if (CAPTURE_EVENT_IN) begin
			flag_set[`TCOU_FLAG_CAP] = 1'b1;
		end
		for (i = 0; i < NCH; i = i + 1) begin
			act = ctrl_reg[`TCOU_CTRL_ACT_LSB + 2*i +: 2];
			match_fire[i] = TIMER_TICK_IN && seen_reg[i];
			flag_set[i] = match_fire[i];
			// Forcing never touches the flag, only the output state.
			act_fire[i] = match_fire[i] || (!pwm && wr_go && w_lo_en_reg && wr_sel == `TCOU_SEL_FORCE &&
				w_data_reg[i]);
			if (act_fire[i]) begin
				// The action is read live from the control register, so a new setting rules the next match.
				case (act)
					`TCOU_ACT_TOGGLE: state_next[i] = !state_reg[i];
					`TCOU_ACT_CLEAR: state_next[i] = pwm ? 1'b0 : 1'b0;
					`TCOU_ACT_SET: state_next[i] = 1'b1;
					default: state_next[i] = state_reg[i];
				endcase
			end else if (pwm && TIMER_TICK_IN && COUNTER_FLOOR_IN) begin
				if (act == `TCOU_ACT_CLEAR) begin
					state_next[i] = 1'b1;
				end else if (act == `TCOU_ACT_SET) begin
					state_next[i] = 1'b0;
				end
			end
		end
		// Set wins over clear so that no event is lost.
		flags_next = (flags_reg & ~flag_clr) | flag_set;
		rd_data = 8'h00;
		rd_err = 1'b0;
		view = 16'h0000;
		case (rd_sel)
			`TCOU_SEL_CTRL: rd_data = ctrl_reg;
			`TCOU_SEL_FLAGS: rd_data = {5'h00, flags_reg};
			`TCOU_SEL_FORCE: rd_data = 8'h00;
			`TCOU_SEL_STATUS: rd_data = {5'h00, pwm, state_reg};
			`TCOU_SEL_CAP_LO: rd_data = capture_reg[7:0];
			`TCOU_SEL_CAP_HI: rd_data = temp_reg;
			`TCOU_SEL_NONE: rd_err = 1'b1;
			default: begin
				view = pwm ? buffer_reg[(rd_sel[1]) * 16 +: 16] : active_reg[(rd_sel[1]) * 16 +: 16];
				rd_data = rd_sel[0] ? view[15:8] : view[7:0];
			end
		endcase
	end

	always @(posedge SYS_CLK_IN) begin
		if (RESET_IN) begin
			aw_ready_reg <= 1'b1;
			w_ready_reg <= 1'b1;
			b_valid_reg <= 1'b0;
			b_resp_reg <= `TCOU_RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 8'h00;
			w_lo_en_reg <= 1'b0;
			ar_ready_reg <= 1'b1;
			r_valid_reg <= 1'b0;
			r_resp_reg <= `TCOU_RESP_OKAY;
			r_data_reg <= 8'h00;
			ctrl_reg <= `TCOU_CTRL_RESET;
			flags_reg <= 3'h0;
			irq_reg <= 3'h0;
			temp_reg <= 8'h00;
			active_reg <= {16*NCH{1'b0}};
			buffer_reg <= {16*NCH{1'b0}};
			capture_reg <= 16'h0000;
			seen_reg <= {NCH{1'b0}};
			block_reg <= 1'b0;
			state_reg <= {NCH{1'b0}};
			pin_reg <= {NCH{1'b0}};
			oe_reg <= {NCH{1'b0}};
		end else begin
			// Write channel: address and data are taken in either order.
			if (aw_ready_reg && S_AXI_AWVALID_IN) begin
				aw_addr_reg <= S_AXI_AWADDR_IN;
				aw_ready_reg <= 1'b0;
			end
			if (w_ready_reg && S_AXI_WVALID_IN) begin
				w_data_reg <= S_AXI_WDATA_IN[7:0];
				w_lo_en_reg <= S_AXI_WSTRB_IN[0];
				w_ready_reg <= 1'b0;
			end
			if (wr_go) begin
				b_valid_reg <= 1'b1;
				b_resp_reg <= (wr_sel == `TCOU_SEL_NONE) ? `TCOU_RESP_DECERR : `TCOU_RESP_OKAY;
			end
			if (b_valid_reg && S_AXI_BREADY_IN) begin
				b_valid_reg <= 1'b0;
				aw_ready_reg <= 1'b1;
				w_ready_reg <= 1'b1;
			end
			// Read channel answers one cycle after the address is taken.
			if (rd_take) begin
				ar_ready_reg <= 1'b0;
				r_valid_reg <= 1'b1;
				r_data_reg <= rd_data;
				r_resp_reg <= rd_err ? `TCOU_RESP_DECERR : `TCOU_RESP_OKAY;
				if (rd_sel == `TCOU_SEL_CAP_LO) begin
					// Capture high byte is frozen in the holding register with the low byte read.
					temp_reg <= capture_reg[15:8];
				end
			end
			if (r_valid_reg && S_AXI_RREADY_IN) begin
				r_valid_reg <= 1'b0;
				ar_ready_reg <= 1'b1;
			end
			// Capture does not look at the output actions at all.
			if (CAPTURE_EVENT_IN) begin
				capture_reg <= COUNTER_VALUE_IN;
			end
			// A counter write holds the block until a tick has passed; a tick clears it.
			if (COUNTER_WRITE_IN) begin
				block_reg <= 1'b1;
			end else if (TIMER_TICK_IN) begin
				block_reg <= 1'b0;
			end
			for (i = 0; i < NCH; i = i + 1) begin
				if (TIMER_TICK_IN) begin
					seen_reg[i] <= (COUNTER_VALUE_IN == active_reg[i*16 +: 16]) && !block_reg &&
						!COUNTER_WRITE_IN;
				end
				if (pwm && TIMER_TICK_IN && (COUNTER_TOP_IN || COUNTER_FLOOR_IN)) begin
					active_reg[i*16 +: 16] <= buffer_reg[i*16 +: 16];
				end
				if (wr_go && w_lo_en_reg && wr_sel == `TCOU_SEL_CMP_LO + 2*i) begin
					if (pwm) begin
						buffer_reg[i*16 +: 16] <= {temp_reg, w_data_reg};
					end else begin
						active_reg[i*16 +: 16] <= {temp_reg, w_data_reg};
					end
				end
				pin_reg[i] <= (ctrl_reg[`TCOU_CTRL_ACT_LSB + 2*i +: 2] != `TCOU_ACT_NONE) ? state_next[i] :
					PORT_VALUE_IN[i];
				oe_reg[i] <= PIN_DIRECTION_BIT_IN[i];
			end
			if (wr_go && w_lo_en_reg) begin
				if (wr_sel == `TCOU_SEL_CTRL) begin
					ctrl_reg <= {1'b0, w_data_reg[6:0]};
				end
				if (wr_sel == 4'h5 || wr_sel == 4'h7 || wr_sel == `TCOU_SEL_CAP_HI) begin
					temp_reg <= w_data_reg;
				end
			end
			state_reg <= state_next;
			flags_reg <= flags_next;
			irq_reg <= flags_next & {ctrl_reg[`TCOU_CTRL_CAP_IE], ctrl_reg[`TCOU_CTRL_IE_LSB +: 2]};
		end
	end

	assign S_AXI_AWREADY_OUT = aw_ready_reg;
	assign S_AXI_WREADY_OUT = w_ready_reg;
	assign S_AXI_BVALID_OUT = b_valid_reg;
	assign S_AXI_BRESP_OUT = b_resp_reg;
	assign S_AXI_ARREADY_OUT = ar_ready_reg;
	assign S_AXI_RVALID_OUT = r_valid_reg;
	assign S_AXI_RRESP_OUT = r_resp_reg;
	assign S_AXI_RDATA_OUT = {24'h00_0000, r_data_reg};
	assign COMPARE_A_TOP_OUT = active_reg[15:0];
	assign IRQ_OUT = irq_reg;
	assign COMPARE_OUTPUT_STATE_OUT = state_reg;
	assign PIN_OUT = pin_reg;
	assign PIN_OE_OUT = oe_reg;

endmodule

// File: tb/tcou_cpu.sv
`timescale 1ns/1ps
module tcou_cpu (
	// Clock.
	input wire clk_in,
	// Write channels.
	output logic [7:0] awaddr_out = 0,
	output logic awvalid_out = 0,
	input wire awready_in,
	output logic [31:0] wdata_out = 0,
	output logic [3:0] wstrb_out = 0,
	output logic wvalid_out = 0,
	input wire wready_in,
	input wire bvalid_in,
	output logic bready_out = 0,
	// Read channels.
	output logic [7:0] araddr_out = 0,
	output logic arvalid_out = 0,
	input wire arready_in,
	input wire [31:0] rdata_in,
	input wire [1:0] rresp_in,
	input wire rvalid_in,
	output logic rready_out = 0
);
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk_in);
		awaddr_out <= a;
		wdata_out <= {24'h00_0000, d};
		wstrb_out <= 4'h1;
		awvalid_out <= 1;
		wvalid_out <= 1;
		bready_out <= 1;
		do begin
			@(posedge clk_in);
			if (awready_in) awvalid_out <= 0;
			if (wready_in) wvalid_out <= 0;
		end while ((awvalid_out && !awready_in) || (wvalid_out && !wready_in));
		do @(posedge clk_in); while (!bvalid_in);
		bready_out <= 0;
	endtask
	// The low byte goes last because it commits the held high byte.
	task wr16(input [7:0] a, input [15:0] v);
		wr(a + 8'h04, v[15:8]);
		wr(a, v[7:0]);
	endtask
	task rd(input [7:0] a, output [7:0] d, output [1:0] r);
		@(posedge clk_in);
		araddr_out <= a;
		arvalid_out <= 1;
		rready_out <= 1;
		do @(posedge clk_in); while (!arready_in);
		arvalid_out <= 0;
		do @(posedge clk_in); while (!rvalid_in);
		d = rdata_in[7:0];
		r = rresp_in;
		rready_out <= 0;
	endtask
endmodule

// File: tb/tcou_props.sv
`timescale 1ns/1ps
module tcou_chk (
	// Observed top-level ports.
	input wire SYS_CLK_IN,
	input wire RESET_IN,
	input wire S_AXI_BVALID_OUT,
	input wire TIMER_TICK_IN,
	input wire COUNTER_TOP_IN,
	input wire COUNTER_FLOOR_IN,
	input wire CAPTURE_EVENT_IN,
	input wire [2:0] IRQ_ACK_IN,
	input wire [1:0] PORT_VALUE_IN,
	input wire [1:0] PIN_DIRECTION_BIT_IN,
	input wire [15:0] COMPARE_A_TOP_OUT,
	input wire [2:0] IRQ_OUT,
	input wire [1:0] COMPARE_OUTPUT_STATE_OUT,
	input wire [1:0] PIN_OUT,
	input wire [1:0] PIN_OE_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (RESET_IN);
	a_oe_dir: assert property (!$past(RESET_IN) |-> PIN_OE_OUT == $past(PIN_DIRECTION_BIT_IN))
		else $error("pin enable does not follow direction");
	a_pin_src: assert property (!$past(RESET_IN) |-> PIN_OUT[0] == COMPARE_OUTPUT_STATE_OUT[0] ||
		PIN_OUT[0] == $past(PORT_VALUE_IN[0])) else $error("pin A has neither source");
	a_rst_state: assert property (disable iff (1'b0) RESET_IN |=> COMPARE_OUTPUT_STATE_OUT == 2'b00)
		else $error("output state not cleared by reset");
	a_state_cause: assert property ($changed(COMPARE_OUTPUT_STATE_OUT) |->
		$past(TIMER_TICK_IN) || $rose(S_AXI_BVALID_OUT)) else $error("output state moved without cause");
	a_top_cause: assert property ($changed(COMPARE_A_TOP_OUT) |-> $rose(S_AXI_BVALID_OUT) ||
		$past(TIMER_TICK_IN) && ($past(COUNTER_TOP_IN) || $past(COUNTER_FLOOR_IN)))
		else $error("compare A moved outside write or top or floor");
	a_irq_clear: assert property ($fell(IRQ_OUT[0]) |-> $past(IRQ_ACK_IN[0]) || $rose(S_AXI_BVALID_OUT))
		else $error("match A request dropped without clear");
	a_cap_set: assert property ($rose(IRQ_OUT[2]) |-> $past(CAPTURE_EVENT_IN) || $rose(S_AXI_BVALID_OUT))
		else $error("capture request without event");
	a_match_tick: assert property ($rose(IRQ_OUT[0]) |-> $past(TIMER_TICK_IN) || $rose(S_AXI_BVALID_OUT))
		else $error("match A request off a timer tick");
endmodule
bind tcou_top tcou_chk chk_u (.SYS_CLK_IN, .RESET_IN, .S_AXI_BVALID_OUT, .TIMER_TICK_IN, .COUNTER_TOP_IN,
	.COUNTER_FLOOR_IN, .CAPTURE_EVENT_IN, .IRQ_ACK_IN, .PORT_VALUE_IN, .PIN_DIRECTION_BIT_IN, .COMPARE_A_TOP_OUT,
	.IRQ_OUT, .COMPARE_OUTPUT_STATE_OUT, .PIN_OUT, .PIN_OE_OUT);

// File: tb/tcou_top_tb.sv
`timescale 1ns/1ps
`include "tcou_consts.vh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end end
module tcou_top_tb;
	logic clk = 0, rst = 1, tick = 0, top = 0, flr = 0, cwr = 0, cap = 0;
	logic [15:0] cnt = 0;
	logic [3:0] mode = 0;
	logic [2:0] ack = 0;
	logic [1:0] port = 0, dir = 0, r;
	logic [7:0] aw, ar, d;
	logic [31:0] wd, rdat;
	logic [3:0] ws;
	logic awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
	logic [1:0] rresp, bresp, st, pin, oe;
	logic [15:0] atop;
	logic [2:0] irq;
	int error_cnt = 0, checks = 0, cyc = 0;
	always #12.5 clk = ~clk;
	tcou_cpu cpu_u (.clk_in(clk), .awaddr_out(aw), .awvalid_out(awv), .awready_in(awr), .wdata_out(wd),
		.wstrb_out(ws), .wvalid_out(wv), .wready_in(wr_), .bvalid_in(bv), .bready_out(br), .araddr_out(ar),
		.arvalid_out(arv), .arready_in(arr), .rdata_in(rdat), .rresp_in(rresp), .rvalid_in(rv), .rready_out(rr));
	tcou_top dut_u (.SYS_CLK_IN(clk), .RESET_IN(rst), .S_AXI_AWADDR_IN(aw), .S_AXI_AWVALID_IN(awv),
		.S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv),
		.S_AXI_WREADY_OUT(wr_), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
		.S_AXI_ARADDR_IN(ar), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat),
		.S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr), .TIMER_TICK_IN(tick),
		.COUNTER_VALUE_IN(cnt), .COUNTER_TOP_IN(top), .COUNTER_FLOOR_IN(flr), .COUNTER_WRITE_IN(cwr),
		.WAVEFORM_MODE_SELECT_IN(mode), .CAPTURE_EVENT_IN(cap), .IRQ_ACK_IN(ack), .PORT_VALUE_IN(port),
		.PIN_DIRECTION_BIT_IN(dir), .COMPARE_A_TOP_OUT(atop), .IRQ_OUT(irq), .COMPARE_OUTPUT_STATE_OUT(st),
		.PIN_OUT(pin), .PIN_OE_OUT(oe));
	task test_done;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// One timer tick with the counter at v; the equality seen here acts only on the next tick.
	task tk(input [15:0] v, input t, input f);
		@(posedge clk);
		cnt <= v; tick <= 1; top <= t; flr <= f;
		@(posedge clk);
		tick <= 0; top <= 0; flr <= 0;
		#1;
	endtask
	task rdc(input [7:0] a, input [7:0] e);
		cpu_u.rd(a, d, r);
		`CHK("read data", e, d)
		`CHK("read resp", (a == 8'h30) ? 2'b11 : 2'b00, r)
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			test_done;
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 0;
		rdc(`TCOU_OFF_STATUS, 8'h00);
		cpu_u.wr(`TCOU_OFF_CTRL, 8'h7D);
		rdc(`TCOU_OFF_CTRL, 8'h7D);
		cpu_u.wr(`TCOU_OFF_FORCE, 8'h03);
		rdc(`TCOU_OFF_STATUS, 8'h03);
		`CHK("irq after force", 3'b000, irq)
		@(posedge clk) dir <= 2'b11;
		repeat (2) @(posedge clk);
		`CHK("pin", 2'b11, pin)
		`CHK("oe", 2'b11, oe)
		cpu_u.wr16(`TCOU_OFF_CMPA_LO, 16'h1234);
		`CHK("top", 16'h1234, atop)
		rdc(`TCOU_OFF_CMPA_HI, 8'h12);
		tk(16'h1234, 0, 0);
		`CHK("flag early", 1'b0, irq[0])
		tk(16'h0001, 0, 0);
		`CHK("flag", 1'b1, irq[0])
		`CHK("toggle", 2'b10, st)
		@(posedge clk) ack <= 3'b001;
		@(posedge clk) ack <= 3'b000;
		#1 `CHK("ack", 1'b0, irq[0])
		// The counter is written in normal mode, so the equality at the next tick is blocked and no match follows.
		@(posedge clk) cwr <= 1;
		@(posedge clk) cwr <= 0;
		tk(16'h1234, 0, 0);
		tk(16'h0001, 0, 0);
		`CHK("blocked", 1'b0, irq[0])
		tk(16'h1234, 0, 0);
		tk(16'h0001, 0, 0);
		`CHK("unblocked", 2'b11, {irq[0], st[0]})
		cpu_u.wr(`TCOU_OFF_FLAGS, 8'h01);
		`CHK("w1c", 1'b0, irq[0])
		cpu_u.wr(`TCOU_OFF_CTRL, 8'h7C);
		tk(16'h1234, 0, 0);
		tk(16'h0001, 0, 0);
		`CHK("no action", 2'b11, st)
		`CHK("port pin", 2'b10, pin)
		@(posedge clk) mode <= 4'hE;
		cpu_u.wr16(`TCOU_OFF_CMPA_LO, 16'h00AA);
		`CHK("buffered", 16'h1234, atop)
		rdc(`TCOU_OFF_CMPA_LO, 8'hAA);
		rdc(`TCOU_OFF_STATUS, 8'h07);
		tk(16'h0001, 1, 0);
		`CHK("top load", 16'h00AA, atop)
		tk(16'h0002, 0, 1);
		`CHK("floor action", 2'b01, st)
		`CHK("floor pin", 2'b00, pin)
		@(posedge clk) begin cnt <= 16'h5678; cap <= 1; end
		@(posedge clk) cnt <= 16'h9ABC;
		#1 `CHK("cap flag", 1'b1, irq[2])
		@(posedge clk) cap <= 0;
		rdc(`TCOU_OFF_CAP_LO, 8'hBC);
		rdc(`TCOU_OFF_CAP_HI, 8'h9A);
		cpu_u.wr(`TCOU_OFF_FLAGS, 8'h04);
		`CHK("cap clear", 1'b0, irq[2])
		cpu_u.wr(8'h30, 8'h00);
		`CHK("write resp", 2'b11, bresp)
		rdc(8'h30, 8'h00);
		test_done;
	end
endmodule
